/* File: core/resp_electrode_off_config_pkg.sv */
// constants, field layouts and carrier types for respiration and electrode-off control
package resp_electrode_off_config_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ             = 200_000_000;
  localparam int MOD_RATE_LOW_KHZ   = 32;
  localparam int MOD_RATE_HIGH_KHZ  = 64;
  localparam int MOD_PERIOD_LOW_CYC = CLK_HZ / (MOD_RATE_LOW_KHZ * 1000);
  // 11.25 degrees per code at the low rate is one 32nd of a period
  localparam int PHASE_STEPS_LOW    = 32;
  localparam int SAMPLE_LEAD_CYC    = 2;
  localparam int AC_EXC_DIVIDE      = 4;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_RESP_CFG   = 8'h00;
  localparam logic [7:0] OFS_BD_CFG     = 8'h04;
  localparam logic [7:0] OFS_ELECTRODE_OFF_CONFIG_CFG   = 8'h08;
  localparam logic [7:0] OFS_AUX        = 8'h0C;
  localparam logic [7:0] OFS_STATE      = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int ELECTRODE_OFF_CONFIG_THRESH_LSB = 5;
  localparam int ELECTRODE_OFF_CONFIG_AC_MODE    = 0;
  localparam int AUX_DIR_LSB     = 2;
  localparam int IRQ_BD_OFF      = 0;
  localparam int IRQ_SAMPLE      = 1;

  localparam logic [7:0] RESP_CFG_RESET = 8'h00;
  localparam logic [2:0] BD_CFG_RESET   = 3'h1;
  localparam logic [7:0] ELECTRODE_OFF_CONFIG_CFG_RESET = 8'h00;
  localparam logic [1:0] AUX_DIR_RESET  = 2'h3;
  localparam logic [1:0] AXI_OKAY       = 2'h0;
  localparam logic [1:0] AXI_SLVERR     = 2'h2;

  typedef struct packed {
    logic [3:0] demod_phase;
    logic       mod_rate_select;
    logic       demodulator_on;
    logic       modulator_on;
    logic       clock_source_select;
  } resp_cfg_s;

  typedef struct packed {
    logic pu_check_on;
    logic amp_power;
    logic ref_internal;
  } bd_cfg_s;

endpackage

/* File: core/resp_clock_gen.sv */
// internal respiration modulation square wave and phase-shifted demodulation reference
`timescale 1ns/100ps
`default_nettype none
module resp_clock_gen #(
  parameter int PERIOD_LOW = resp_electrode_off_config_pkg::MOD_PERIOD_LOW_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       rate_select,
  input  wire logic [3:0] phase_code,
  output logic            mod_wave,
  output logic            demod_wave
);

  localparam int          STEP  = PERIOD_LOW / resp_electrode_off_config_pkg::PHASE_STEPS_LOW;
  localparam logic [15:0] P_LOW = 16'(PERIOD_LOW);
  localparam logic [15:0] STEPW = 16'(STEP);

  // refused at elaboration: a shorter period leaves fewer than two whole cycles per phase step
  if (PERIOD_LOW < 2 * resp_electrode_off_config_pkg::PHASE_STEPS_LOW || PERIOD_LOW > 65535)
  begin
    $error("resp_clock_gen: PERIOD_LOW out of range");
  end

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [15:0] period;
  logic [15:0] delay;
  logic [15:0] pos;
  logic [3:0]  code;

  // at the high rate the period halves, so the same step is 22.5 degrees and
  // the top phase bit must be dropped to stay under a half period
  always_comb
  begin
    period   = rate_select ? (P_LOW >> 1) : P_LOW;  // R12 R15
    code     = rate_select ? {1'b0, phase_code[2:0]} : phase_code;  // R16
    delay    = 16'(code * STEPW);  // R16
    pos      = (cnt >= delay) ? cnt - delay : 16'(cnt + period - delay);
    next_cnt = (!run || cnt >= period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt        <= 16'h0000;
      mod_wave   <= 1'b0;
      demod_wave <= 1'b0;
    end
    else
    begin
      cnt        <= next_cnt;
      mod_wave   <= run && (cnt < (period >> 1));
      demod_wave <= run && (pos < (period >> 1));
    end
  end

endmodule
`default_nettype wire

/* File: core/resp_electrode_off_config_ctrl.sv */
// respiration, electrode-off excitation, body-drive and aux-pin control with AXI4-Lite registers
//
// Functional notes
// [R1] ac electrode-off alternates current source and sink at sample rate over four
// [R2] body-drive electrode-off checked in normal run and at power-up with a sink
// [R3] power-up sink disabled while body-drive amplifier runs; comparator alone reports
// [R4] body-drive comparator threshold comes from electrode-off config bits 7 to 5
// [R5] reference select picks internal mid-supply or external body-drive reference
// [R6] clearing the amplifier power bit powers the body-drive amplifier down
// [R7] aux pin data latched two clocks before sample ready falls, sent with sample
// [R8] clock source select: 0 internal clock, 1 external clock
// [R9] modulator and demodulator have separate enable bits
// [R10] enabled modulator drives square wave on positive and negative outputs
// [R11] internal clock mode leaves aux pins under normal direction and data control
// [R12] internal clock mode takes modulation frequency from rate select bit
// [R13] external clock mode forces both aux pins to inputs
// [R14] channel one carries respiration data only while respiration is on
// [R15] rate select 0 gives 32 kHz (default), 1 gives 64 kHz
// [R16] phase code steps 11.25 degrees at 32 kHz, 22.5 at 64 kHz
// [R17] aux direction bit: 0 output, 1 input, input after reset
// [R18] external controller supplies continuous modulation clock and phase on aux pins
`timescale 1ns/100ps
`default_nettype none
module resp_electrode_off_config_ctrl #(
  parameter int MOD_PERIOD_LOW = resp_electrode_off_config_pkg::MOD_PERIOD_LOW_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        conv_done,
  input  wire logic        data_taken,
  input  wire logic        bd_comp_in,
  input  wire logic        aux_pin_one_in,
  input  wire logic        aux_pin_two_in,
  output logic             aux_pin_one_out,
  output logic             aux_pin_one_oe,
  output logic             aux_pin_two_out,
  output logic             aux_pin_two_oe,
  output logic             sample_ready_n,
  output logic [1:0]       aux_sample,
  output logic             exc_source_on,
  output logic             exc_sink_on,
  output logic             bd_pu_sink_on,
  output logic             body_drive_amp_power,
  output logic             body_drive_ref_internal,
  output logic [2:0]       comp_threshold,
  output logic             resp_mod_out_pos,
  output logic             resp_mod_out_neg,
  output logic             resp_demod_ref,
  output logic             ch1_resp_only,
  output logic             irq
);

  localparam int AC_W = $clog2(resp_electrode_off_config_pkg::AC_EXC_DIVIDE);

  // the two-bit lead counter and the top-bit excitation split only serve these values
  if (resp_electrode_off_config_pkg::SAMPLE_LEAD_CYC < 1 || resp_electrode_off_config_pkg::AC_EXC_DIVIDE != 4)
  begin
    $error("resp_electrode_off_config_ctrl: unsupported timing constants");
  end

  typedef enum {ST_IDLE, ST_LEAD, ST_READY} smp_state_e;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == resp_electrode_off_config_pkg::OFS_RESP_CFG) || (a == resp_electrode_off_config_pkg::OFS_BD_CFG)
          || (a == resp_electrode_off_config_pkg::OFS_ELECTRODE_OFF_CONFIG_CFG) || (a == resp_electrode_off_config_pkg::OFS_AUX)
          || (a == resp_electrode_off_config_pkg::OFS_STATE) || (a == resp_electrode_off_config_pkg::OFS_IRQ_STATUS)
          || (a == resp_electrode_off_config_pkg::OFS_IRQ_MASK);
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       aux_one_s;
  logic       aux_two_s;
  logic       bd_comp_s;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end
    else
    begin
      sync_a <= {bd_comp_in, aux_pin_two_in, aux_pin_one_in};
      sync_b <= sync_a;
    end
  end

  assign {bd_comp_s, aux_two_s, aux_one_s} = sync_b;

  // ----------------------------------------------------------------------
  // registers and AXI4-Lite slave
  // ----------------------------------------------------------------------
  resp_electrode_off_config_pkg::resp_cfg_s resp_cfg, next_resp_cfg;
  resp_electrode_off_config_pkg::bd_cfg_s   bd_cfg, next_bd_cfg;
  logic [7:0]  electrode_off_config_cfg, next_electrode_off_config_cfg;
  logic [1:0]  aux_dir, next_aux_dir;
  logic [1:0]  aux_data, next_aux_data;
  logic [1:0]  irq_status, next_irq_status;
  logic [1:0]  irq_mask, next_irq_mask;
  logic        aw_held, next_aw_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic        w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic        w_lane, next_w_lane;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;
  logic        wr_fire;
  logic        bd_off;
  logic        bd_off_q;
  logic        sample_event;
  logic [1:0]  events;

  assign wr_fire = aw_held && w_held && !bvalid;
  assign events  = {sample_event, bd_off && !bd_off_q};

  always_comb
  begin
    next_resp_cfg   = resp_cfg;
    next_bd_cfg     = bd_cfg;
    next_electrode_off_config_cfg   = electrode_off_config_cfg;
    next_aux_dir    = aux_dir;
    next_aux_data   = aux_data;
    next_irq_mask   = irq_mask;
    next_irq_status = irq_status;
    next_aw_held    = aw_held || s_axi_awvalid;
    next_aw_addr    = aw_held ? aw_addr : s_axi_awaddr;
    next_w_held     = w_held || s_axi_wvalid;
    next_w_data     = w_held ? w_data : s_axi_wdata;
    next_w_lane     = w_held ? w_lane : s_axi_wstrb[0];
    next_bvalid     = bvalid && !s_axi_bready;
    next_bresp      = bresp;
    next_rvalid     = rvalid && !s_axi_rready;
    next_rdata      = rdata;
    next_rresp      = rresp;
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? resp_electrode_off_config_pkg::AXI_OKAY : resp_electrode_off_config_pkg::AXI_SLVERR;
      if (w_lane)
      begin
        unique case (aw_addr)
          resp_electrode_off_config_pkg::OFS_RESP_CFG:   next_resp_cfg = w_data[7:0];  // R8 R9
          resp_electrode_off_config_pkg::OFS_BD_CFG:     next_bd_cfg = w_data[2:0];  // R5 R6
          resp_electrode_off_config_pkg::OFS_ELECTRODE_OFF_CONFIG_CFG:   next_electrode_off_config_cfg = w_data[7:0];
          resp_electrode_off_config_pkg::OFS_AUX:
          begin
            next_aux_data = w_data[1:0];
            next_aux_dir  = w_data[resp_electrode_off_config_pkg::AUX_DIR_LSB +: 2];  // R17
          end
          resp_electrode_off_config_pkg::OFS_IRQ_STATUS: next_irq_status = irq_status & ~w_data[1:0];
          resp_electrode_off_config_pkg::OFS_IRQ_MASK:   next_irq_mask = w_data[1:0];
          default:                       next_irq_mask = irq_mask;
        endcase
      end
    end
    // a new event outranks a clear in the same cycle
    next_irq_status = next_irq_status | events;
    if (s_axi_arvalid && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(s_axi_araddr) ? resp_electrode_off_config_pkg::AXI_OKAY : resp_electrode_off_config_pkg::AXI_SLVERR;
      unique case (s_axi_araddr)
        resp_electrode_off_config_pkg::OFS_RESP_CFG:   next_rdata = {24'h00_0000, resp_cfg};
        resp_electrode_off_config_pkg::OFS_BD_CFG:     next_rdata = {29'h0000_0000, bd_cfg};
        resp_electrode_off_config_pkg::OFS_ELECTRODE_OFF_CONFIG_CFG:   next_rdata = {24'h00_0000, electrode_off_config_cfg};
        resp_electrode_off_config_pkg::OFS_AUX:        next_rdata = {28'h000_0000, aux_dir, aux_two_s, aux_one_s};
        resp_electrode_off_config_pkg::OFS_STATE:      next_rdata = {27'h000_0000, aux_sample, sample_ready_n,
                                                     bd_pu_sink_on, bd_off};
        resp_electrode_off_config_pkg::OFS_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_status};
        resp_electrode_off_config_pkg::OFS_IRQ_MASK:   next_rdata = {30'h0000_0000, irq_mask};
        default:                       next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      resp_cfg   <= resp_electrode_off_config_pkg::RESP_CFG_RESET;
      bd_cfg     <= resp_electrode_off_config_pkg::BD_CFG_RESET;
      electrode_off_config_cfg   <= resp_electrode_off_config_pkg::ELECTRODE_OFF_CONFIG_CFG_RESET;
      aux_dir    <= resp_electrode_off_config_pkg::AUX_DIR_RESET;
      aux_data   <= 2'h0;
      irq_status <= 2'h0;
      irq_mask   <= 2'h0;
      aw_held    <= 1'b0;
      aw_addr    <= 8'h00;
      w_held     <= 1'b0;
      w_data     <= 32'h0000_0000;
      w_lane     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= resp_electrode_off_config_pkg::AXI_OKAY;
      rvalid     <= 1'b0;
      rdata      <= 32'h0000_0000;
      rresp      <= resp_electrode_off_config_pkg::AXI_OKAY;
      bd_off_q   <= 1'b0;
    end
    else
    begin
      resp_cfg   <= next_resp_cfg;
      bd_cfg     <= next_bd_cfg;
      electrode_off_config_cfg   <= next_electrode_off_config_cfg;
      aux_dir    <= next_aux_dir;
      aux_data   <= next_aux_data;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      aw_held    <= next_aw_held;
      aw_addr    <= next_aw_addr;
      w_held     <= next_w_held;
      w_data     <= next_w_data;
      w_lane     <= next_w_lane;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      rvalid     <= next_rvalid;
      rdata      <= next_rdata;
      rresp      <= next_rresp;
      bd_off_q   <= bd_off;
    end
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign irq           = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------
  // sample timing and ac excitation
  // ----------------------------------------------------------------------
  smp_state_e state, next_state;
  logic [1:0]      lead_cnt, next_lead_cnt;
  logic [1:0]      next_aux_sample;
  logic [AC_W-1:0] ac_cnt, next_ac_cnt;

  always_comb
  begin
    next_state      = state;
    next_lead_cnt   = lead_cnt;
    next_aux_sample = aux_sample;
    next_ac_cnt     = ac_cnt;
    sample_event    = 1'b0;
    unique case (state)
      ST_IDLE:
        if (conv_done)
        begin
          next_aux_sample = {aux_two_s, aux_one_s};  // R7
          next_lead_cnt   = 2'(resp_electrode_off_config_pkg::SAMPLE_LEAD_CYC - 1);
          next_state      = ST_LEAD;
        end
      ST_LEAD:
        if (lead_cnt == 2'h0)
        begin
          next_state   = ST_READY;  // R7
          sample_event = 1'b1;
          next_ac_cnt  = ac_cnt + 1'b1;  // R1
        end
        else
          next_lead_cnt = lead_cnt - 2'h1;
      ST_READY:
        if (data_taken)
          next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state      <= ST_IDLE;
      lead_cnt   <= 2'h0;
      aux_sample <= 2'h0;
      ac_cnt     <= '0;
    end
    else
    begin
      state      <= next_state;
      lead_cnt   <= next_lead_cnt;
      aux_sample <= next_aux_sample;
      ac_cnt     <= next_ac_cnt;
    end
  end

  assign sample_ready_n = (state != ST_READY);
  // half of the four-sample cycle on the source, half on the sink
  assign exc_source_on  = electrode_off_config_cfg[resp_electrode_off_config_pkg::ELECTRODE_OFF_CONFIG_AC_MODE] && !ac_cnt[AC_W-1];  // R1
  assign exc_sink_on    = electrode_off_config_cfg[resp_electrode_off_config_pkg::ELECTRODE_OFF_CONFIG_AC_MODE] && ac_cnt[AC_W-1];  // R1

  // ----------------------------------------------------------------------
  // body drive and respiration
  // ----------------------------------------------------------------------
  logic ext_mode;
  logic int_mod;
  logic int_demod;
  logic mod_wave;

  assign body_drive_amp_power    = bd_cfg.amp_power;  // R6
  assign body_drive_ref_internal = bd_cfg.ref_internal;  // R5
  assign comp_threshold          = electrode_off_config_cfg[resp_electrode_off_config_pkg::ELECTRODE_OFF_CONFIG_THRESH_LSB +: 3];  // R4
  assign bd_pu_sink_on           = bd_cfg.pu_check_on && !bd_cfg.amp_power;  // R2 R3
  assign bd_off                  = bd_comp_s;  // R2 R3

  resp_clock_gen #(
    .PERIOD_LOW (MOD_PERIOD_LOW)
  ) u_clock_gen (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .run         (!ext_mode && (resp_cfg.modulator_on || resp_cfg.demodulator_on)),
    .rate_select (resp_cfg.mod_rate_select),
    .phase_code  (resp_cfg.demod_phase),
    .mod_wave    (int_mod),
    .demod_wave  (int_demod)
  );

  // in external mode the host's clock and phase arrive synchronised on the aux pins
  assign ext_mode         = resp_cfg.clock_source_select;  // R8
  assign mod_wave         = ext_mode ? aux_one_s : int_mod;  // R18
  assign resp_mod_out_pos = resp_cfg.modulator_on && mod_wave;  // R10
  assign resp_mod_out_neg = resp_cfg.modulator_on && !mod_wave;  // R10
  assign resp_demod_ref   = resp_cfg.demodulator_on && (ext_mode ? aux_two_s : int_demod);  // R9
  assign ch1_resp_only    = resp_cfg.modulator_on || resp_cfg.demodulator_on;  // R14
  assign aux_pin_one_out  = aux_data[0];
  assign aux_pin_two_out  = aux_data[1];
  assign aux_pin_one_oe   = !ext_mode && !aux_dir[0];  // R11 R13 R17
  assign aux_pin_two_oe   = !ext_mode && !aux_dir[1];  // R11 R13 R17

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_sink_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    bd_pu_sink_on |-> !body_drive_amp_power) else $error("sink active with amp on"); // R3
  a_lead_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_IDLE && conv_done) |=> sample_ready_n ##1 sample_ready_n ##1 !sample_ready_n)
    else $error("sample ready not two clocks after latch"); // R7
  a_latch_value: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_IDLE && conv_done) |=> aux_sample == $past(sync_b[1:0]))
    else $error("aux sample not latched"); // R7
  a_thresh_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && w_lane && aw_addr == resp_electrode_off_config_pkg::OFS_ELECTRODE_OFF_CONFIG_CFG)
    |=> comp_threshold == $past(w_data[7:5])) else $error("threshold not taken"); // R4
  a_power_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && w_lane && aw_addr == resp_electrode_off_config_pkg::OFS_BD_CFG)
    |=> body_drive_amp_power == $past(w_data[1]) && body_drive_ref_internal == $past(w_data[0]))
    else $error("body drive config not taken"); // R5 R6
  a_aux_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_mode |-> !aux_pin_one_oe && !aux_pin_two_oe) else $error("aux driven in ext mode"); // R13
  a_aux_normal: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ext_mode && aux_dir == 2'h0) |-> aux_pin_one_oe && aux_pin_two_oe)
    else $error("aux output not driven"); // R11
  a_mod_outputs: assert property (@(posedge aclk) disable iff (!aresetn)
    resp_cfg.modulator_on ? (resp_mod_out_pos != resp_mod_out_neg)
                          : (!resp_mod_out_pos && !resp_mod_out_neg))
    else $error("modulation outputs wrong"); // R10
  a_ac_alternate: assert property (@(posedge aclk) disable iff (!aresetn)
    (sample_event && electrode_off_config_cfg[0] && ac_cnt == 2'h1 && $stable(electrode_off_config_cfg))
    |=> $rose(exc_sink_on)) else $error("ac excitation did not swap"); // R1
  a_irq_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    sample_event |=> irq_status[resp_electrode_off_config_pkg::IRQ_SAMPLE]) else $error("event lost");
  a_bus_order: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid && !aw_held && !w_held) else $error("write not answered");

  c_sample: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(sample_ready_n));
  c_ext_mode: cover property (@(posedge aclk) disable iff (!aresetn)
    ext_mode && resp_cfg.modulator_on && $rose(resp_mod_out_pos));
  c_int_fast: cover property (@(posedge aclk) disable iff (!aresetn)
    !ext_mode && resp_cfg.mod_rate_select && $rose(resp_demod_ref));
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));

endmodule
`default_nettype wire

/* File: dv/far_side_model.sv */
// far-side model: aux pin levels and the external respiration clock pair
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
  input  wire logic       aclk,
  input  wire logic       ext_on,
  input  wire logic [1:0] lvl,
  input  wire logic [1:0] oe,
  input  wire logic [1:0] dout,
  output logic      [1:0] pin
);
  logic [3:0] div = 4'h0;
  always_ff @(posedge aclk) div <= div + 4'h1;
  // the pair never pauses while external mode is in use; the phase line leads a quarter period
  assign pin[0] = oe[0] ? dout[0] : (ext_on ? div[3] : lvl[0]);
  assign pin[1] = oe[1] ? dout[1] : (ext_on ? div[3] ^ div[2] : lvl[1]);
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for respiration, electrode-off and aux-pin control
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready, conv_done, data_taken, ext, bdc;
  logic        awready, wready, bvalid, arready, rvalid, srn, src, snk, pus, amp, refi, o1, o2;
  logic        e1, e2, mp, mn, dr, ch1, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, x;
  logic [1:0]  r, bresp, rresp, lvl, pin, aux_s;
  logic [2:0]  thr;
  logic [3:0]  strb;
  logic [5:0]  s;
  int          n_errors = 0;
  int          total_checks = 0;
  time         t0;
  resp_electrode_off_config_ctrl #(.MOD_PERIOD_LOW(64)) resp_electrode_off_config_ctrl_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_done(conv_done), .data_taken(data_taken), .bd_comp_in(bdc),
    .aux_pin_one_in(pin[0]), .aux_pin_two_in(pin[1]), .aux_pin_one_out(o1),
    .aux_pin_one_oe(e1), .aux_pin_two_out(o2), .aux_pin_two_oe(e2), .sample_ready_n(srn),
    .aux_sample(aux_s), .exc_source_on(src), .exc_sink_on(snk), .bd_pu_sink_on(pus),
    .body_drive_amp_power(amp), .body_drive_ref_internal(refi), .comp_threshold(thr),
    .resp_mod_out_pos(mp), .resp_mod_out_neg(mn), .resp_demod_ref(dr),
    .ch1_resp_only(ch1), .irq(irq));
  far_side_model far_side_model_i (.aclk(aclk), .ext_on(ext), .lvl(lvl), .oe({e2, e1}),
    .dout({o2, o1}), .pin(pin));
  initial forever #2.5 aclk = ~aclk;
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) n_errors++;
    if (g !== e) $display("unexpected at %0t: got %h expected %h", $time, g, e);
  endtask
  // one bus task for both directions keeps the handshake rules in one place
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
    {awaddr, araddr, wdata} <= {a, a, v};
    {awvalid, wvalid, bready, arvalid, rready} <= {{3{wr}}, {2{!wr}}};
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while (!(bvalid || rvalid));
    {d, r} = {rdata, wr ? bresp : rresp};
    {bready, rready} <= 2'h0;
    @(posedge aclk);
  endtask
  task automatic smp;
    conv_done <= 1'b1;
    @(posedge aclk);
    conv_done <= 1'b0;
    @(posedge aclk);
    #1 chk(srn, 1'b1);
    @(posedge aclk);
    #1 chk({srn, aux_s}, {1'b0, lvl});
    data_taken <= 1'b1;
    @(posedge aclk);
    data_taken <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic per(input int p);
    @(posedge mp);
    t0 = $time;
    @(posedge mp);
    #1 chk({mn ^ mp, 31'(($time - t0) / 5)}, {1'b1, 31'(p)});
    @(posedge aclk);
  endtask
  // cycles from a modulation rising edge to the demodulation rising edge
  task automatic ph(input int p);
    @(posedge mp);
    t0 = $time;
    @(posedge dr);
    #1 chk(32'(($time - t0) / 5), 32'(p));
    @(posedge aclk);
  endtask
  // 11.25 degrees of the 64-cycle period, or 22.5 of the 32-cycle one, is two cycles
  function automatic int lag_of(input int code, input bit fast);
    lag_of = (fast ? code % 8 : code) * 2;
  endfunction
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    close_out;
  end
  initial
  begin
    x = $urandom(65643);
    {aresetn, awvalid, wvalid, bready, arvalid, rready, conv_done, data_taken, ext, bdc} <= '0;
    {awaddr, araddr, wdata, lvl} <= '0;
    strb <= 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    bus(1'b0, 8'h04, 32'h0);
    chk(d, 32'h1);
    bus(1'b0, 8'h0c, 32'h0);
    chk({d[3:2], e2, e1, ch1, mp, irq}, 7'h60);
    bus(1'b0, 8'h1c, 32'h0);
    chk({r, d[29:0]}, 32'h8000_0000);
    bus(1'b1, 8'h1c, 32'hffff_ffff);
    chk(r, 2'h2);
    $display("test reset and decode done");
    repeat (8)
    begin
      x = $urandom;
      bus(1'b1, 8'h04, x);
      chk({r, pus, amp, refi}, {2'h0, x[2] & ~x[1], x[1:0]});
      bus(1'b1, 8'h08, x);
      chk(thr, x[7:5]);
    end
    // a write with its low byte lane off must leave the register alone
    strb <= 4'h0;
    bus(1'b1, 8'h08, ~x);
    chk({r, thr}, {2'h0, x[7:5]});
    strb <= 4'hf;
    bus(1'b1, 8'h0c, 32'h3);
    chk({e2, e1, o2, o1}, 4'hf);
    ext <= 1'b1;
    bus(1'b1, 8'h00, 32'h3);
    chk({e2, e1, ch1}, 3'h1);
    per(16);
    bus(1'b1, 8'h00, 32'h0);
    chk({e2, e1}, 2'h3);
    ext <= 1'b0;
    bus(1'b1, 8'h0c, 32'hc);
    lvl <= 2'($urandom);
    bus(1'b1, 8'h18, 32'h2);
    smp;
    chk(irq, 1'b1);
    bus(1'b1, 8'h14, 32'h2);
    chk(irq, 1'b0);
    bus(1'b1, 8'h18, 32'h1);
    bdc <= 1'b1;
    repeat (4) @(posedge aclk);
    bus(1'b0, 8'h10, 32'h0);
    chk({d[2], d[0], irq}, 3'h7);
    // the comparator stays high, so no new edge may set the status again
    bus(1'b1, 8'h14, 32'h1);
    chk(irq, 1'b0);
    bus(1'b1, 8'h08, 32'h1);
    for (int k = 0; k < 6; k++)
    begin
      smp;
      s[k] = src;
      chk(snk ^ src, 1'b1);
    end
    chk(s[5:2] ^ s[3:0], 4'hf);
    $display("test aux pins and samples done");
    bus(1'b1, 8'h00, 32'h2);
    per(64);
    bus(1'b1, 8'h00, 32'ha);
    per(32);
    bus(1'b1, 8'h00, 32'h4);
    chk({ch1, mp, mn}, 3'h4);
    x = 1 + $urandom % 15;
    bus(1'b1, 8'h00, {24'h00_0000, x[3:0], 4'h6});
    ph(lag_of(x, 1'b0));
    bus(1'b1, 8'h00, 32'hde);
    ph(lag_of(13, 1'b1));
    $display("test modulation done");
    close_out;
  end
endmodule
`default_nettype wire
